// file: verilog/fpc_top.sv
// Purpose: Flash program control register block with Avalon-MM slave
// Assumes: resetn is the power-on reset; sys_resetn is any other reset
// Notes: Control bits tied to power-on survive sys_resetn
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module fpc_top (
	// Clock and resets
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sys_resetn,
	// Avalon-MM slave
	input wire logic [fpc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Configuration and flash status
	input wire logic [1:0] dynamic_ecc_config,
	input wire logic supply_low,
	input wire logic cell_fault,
	// Bank mapping
	output logic lower_region_bank2,
	output logic upper_region_bank2,
	// Interrupt
	output logic irq
);
	logic start_reg;
	logic write_arm_reg;
	logic program_fail_flag_reg;
	logic low_supply_error_flag_reg;
	logic program_bank_swap_reg;
	logic boot_bank_swap_reg;
	logic [3:0] operation_code_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_en_reg;
	logic ack_reg;
	logic unlocked;
	logic launch;
	logic ctrl_wr;
	logic [2:0] irq_clr;
	fpc_pkg::fpc_cmd_t cmd;
	fpc_pkg::fpc_result_t res;

	// One wait cycle: every access answers on its second edge
	assign waitrequest = (read || write) && !ack_reg;
	wire take = (read || write) && ack_reg;
	assign ctrl_wr = take && write && address == fpc_pkg::ADDR_CTRL;
	wire key_wr = take && write && address == fpc_pkg::ADDR_KEY;
	assign irq_clr = (take && write && address == fpc_pkg::ADDR_IRQ_STAT) ?
		writedata[2:0] : 3'h0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read || write) && !ack_reg;
		end
	end

	fpc_unlock u_unlock (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.key_wr(key_wr),
		.key_data(writedata),
		.consume(ctrl_wr),
		.unlocked(unlocked)
	);

	// Start is only ever set by an armed, unlocked write
	assign launch = ctrl_wr && write_arm_reg && unlocked && writedata[fpc_pkg::BIT_START] &&
		!start_reg;
	assign cmd.op = operation_code_reg;
	assign cmd.nop = (dynamic_ecc_config == fpc_pkg::ECC_ALWAYS);

	fpc_engine u_engine (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.go(launch),
		.cmd(cmd),
		.supply_low(supply_low),
		.cell_fault(cell_fault),
		.res(res)
	);

	// Power-on reset only for these bits
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			start_reg <= 1'b0;
		end else if (launch) begin
			start_reg <= 1'b1;
		end else if (res.done) begin
			start_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			write_arm_reg <= 1'b0;
		end else if (ctrl_wr) begin
			write_arm_reg <= writedata[fpc_pkg::BIT_ARM];
		end
	end

	// Flags: set on result, cleared by a zero-opcode launch; set wins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			program_fail_flag_reg <= 1'b0;
			low_supply_error_flag_reg <= 1'b0;
		end else begin
			if (res.fail) begin
				program_fail_flag_reg <= 1'b1;
			end else if (launch && operation_code_reg == fpc_pkg::OP_CLEAR) begin
				program_fail_flag_reg <= 1'b0;
			end
			if (res.lowv) begin
				low_supply_error_flag_reg <= 1'b1;
			end else if (launch && operation_code_reg == fpc_pkg::OP_CLEAR) begin
				low_supply_error_flag_reg <= 1'b0;
			end
		end
	end

	// Opcode and swap bits follow the ordinary system reset
	always_ff @(posedge ref_clk or negedge sys_resetn) begin
		if (!sys_resetn) begin
			operation_code_reg <= fpc_pkg::OP_RST;
		end else if (ctrl_wr && !write_arm_reg) begin
			operation_code_reg <= writedata[fpc_pkg::OP_LSB +: 4];
		end
	end

	always_ff @(posedge ref_clk or negedge sys_resetn) begin
		if (!sys_resetn) begin
			program_bank_swap_reg <= 1'b0;
			boot_bank_swap_reg <= 1'b0;
		end else if (ctrl_wr && !write_arm_reg && unlocked) begin
			program_bank_swap_reg <= writedata[fpc_pkg::BIT_PSWAP];
		end else if (ctrl_wr) begin
			boot_bank_swap_reg <= writedata[fpc_pkg::BIT_BSWAP];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lower_region_bank2 <= 1'b0;
			upper_region_bank2 <= 1'b1;
		end else begin
			lower_region_bank2 <= program_bank_swap_reg;
			upper_region_bank2 <= !program_bank_swap_reg;
		end
	end

	// Interrupt status: set beats clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_reg <= fpc_pkg::IRQ_RST;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {res.lowv, res.fail, res.done};
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_en_reg <= fpc_pkg::IRQ_RST;
		end else if (take && write && address == fpc_pkg::ADDR_IRQ_EN) begin
			irq_en_reg <= writedata[2:0];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// Read mux; unused bits and unmapped addresses read zero
	always_comb begin
		readdata = 32'h0000_0000;
		case (address)
			fpc_pkg::ADDR_CTRL: begin
				readdata[fpc_pkg::BIT_START] = start_reg;
				readdata[fpc_pkg::BIT_ARM] = write_arm_reg;
				readdata[fpc_pkg::BIT_FAIL] = program_fail_flag_reg;
				readdata[fpc_pkg::BIT_LOWV] = low_supply_error_flag_reg;
				readdata[fpc_pkg::BIT_PSWAP] = program_bank_swap_reg;
				readdata[fpc_pkg::BIT_BSWAP] = boot_bank_swap_reg;
				readdata[3:0] = operation_code_reg;
			end
			fpc_pkg::ADDR_IRQ_STAT: readdata[2:0] = irq_stat_reg;
			fpc_pkg::ADDR_IRQ_EN: readdata[2:0] = irq_en_reg;
			default: readdata = 32'h0000_0000;
		endcase
	end
endmodule

// file: inc/fpc_pkg.sv
// Purpose: Shared constants and types for the flash program control block
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses
package fpc_pkg;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_KEY = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_EN = 4'hC;
	localparam int ADDR_W = 4;
	localparam int BIT_START = 15;
	localparam int BIT_ARM = 14;
	localparam int BIT_FAIL = 13;
	localparam int BIT_LOWV = 12;
	localparam int BIT_PSWAP = 7;
	localparam int BIT_BSWAP = 6;
	localparam int OP_LSB = 0;
	localparam logic [31:0] KEY1 = 32'hAA99_6655;
	localparam logic [31:0] KEY2 = 32'h5566_99AA;
	localparam logic [3:0] OP_CLEAR = 4'h0;
	localparam logic [3:0] OP_WORD = 4'h1;
	localparam logic [3:0] OP_ROW = 4'h3;
	localparam logic [3:0] OP_PAGE = 4'h4;
	localparam logic [3:0] OP_BULK = 4'h7;
	localparam logic [1:0] ECC_ALWAYS = 2'h0;
	localparam logic [7:0] OP_CYCLES = 8'h10;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [3:0] OP_RST = 4'h0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_LOWV = 2;
	typedef struct packed {
		logic [3:0] op;
		logic nop;
	} fpc_cmd_t;
	typedef struct packed {
		logic done;
		logic fail;
		logic lowv;
	} fpc_result_t;
endpackage

// file: verilog/fpc_unlock.sv
// Purpose: Two-word unlock key detector
// Assumes: Keys written back to back to the key register
// Notes: Unlock is consumed by the next control write
`timescale 1ns/10ps
module fpc_unlock (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Key writes
	input wire logic key_wr,
	input wire logic [31:0] key_data,
	input wire logic consume,
	// Status
	output logic unlocked
);
	logic first_reg;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			first_reg <= 1'b0;
			unlocked <= 1'b0;
		end else if (key_wr) begin
			first_reg <= (key_data == fpc_pkg::KEY1);
			unlocked <= first_reg && (key_data == fpc_pkg::KEY2);
		end else if (consume) begin
			first_reg <= 1'b0;
			unlocked <= 1'b0;
		end
	end
endmodule

// file: verilog/fpc_engine.sv
// Purpose: Timed flash operation engine
// Assumes: Supply and fault inputs steady during an operation
// Notes: Fixed duration stands in for the real cell timing
`timescale 1ns/10ps
module fpc_engine #(
	parameter logic [7:0] CYCLES = fpc_pkg::OP_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Command
	input wire logic go,
	input wire fpc_pkg::fpc_cmd_t cmd,
	// Flash side status
	input wire logic supply_low,
	input wire logic cell_fault,
	// Result
	output fpc_pkg::fpc_result_t res
);
	typedef enum logic [0:0] {FPC_IDLE, FPC_BUSY} fpc_state_t;
	fpc_state_t state_reg;
	logic [7:0] cnt_reg;
	fpc_pkg::fpc_cmd_t cmd_reg;
	logic lowv_seen_reg;

	function automatic logic op_known(input logic [3:0] op);
		op_known = (op == fpc_pkg::OP_CLEAR) || (op == fpc_pkg::OP_WORD) ||
			(op == fpc_pkg::OP_ROW) || (op == fpc_pkg::OP_PAGE) ||
			(op == fpc_pkg::OP_BULK);
	endfunction

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= FPC_IDLE;
			cnt_reg <= 8'h00;
			cmd_reg <= '0;
			lowv_seen_reg <= 1'b0;
			res <= '0;
		end else begin
			res <= '0;
			case (state_reg)
				FPC_IDLE: begin
					if (go) begin
						state_reg <= FPC_BUSY;
						cmd_reg <= cmd;
						cnt_reg <= CYCLES;
						lowv_seen_reg <= 1'b0;
					end
				end
				FPC_BUSY: begin
					if (supply_low && cmd_reg.op != fpc_pkg::OP_CLEAR && !cmd_reg.nop) begin
						lowv_seen_reg <= 1'b1;
					end
					if (cnt_reg == 8'h01 || cmd_reg.nop || cmd_reg.op == fpc_pkg::OP_CLEAR) begin
						state_reg <= FPC_IDLE;
						res.done <= 1'b1;
						// No-op path skips the array entirely
						res.fail <= !cmd_reg.nop && cmd_reg.op != fpc_pkg::OP_CLEAR &&
							(cell_fault || !op_known(cmd_reg.op));
						res.lowv <= lowv_seen_reg || (supply_low && !cmd_reg.nop &&
							cmd_reg.op != fpc_pkg::OP_CLEAR);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				default: state_reg <= FPC_IDLE;
			endcase
		end
	end
endmodule

// file: tb/fpc_top_chk.sv
// Purpose: Port-level checks of fpc_top
// Assumes: resetn is the power-on reset
// Notes: Ports only; internal state not seen
`timescale 1ns/10ps
module fpc_chk (
	// Clock and resets
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sys_resetn,
	// Bus
	input wire logic [fpc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Status and outputs
	input wire logic [1:0] dynamic_ecc_config,
	input wire logic supply_low,
	input wire logic cell_fault,
	input wire logic lower_region_bank2,
	input wire logic upper_region_bank2,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic wr_ctl;
	assign wr_ctl = write && !waitrequest && address == fpc_pkg::ADDR_CTRL;
	sequence s_rd_ctl;
		read && !waitrequest && address == fpc_pkg::ADDR_CTRL;
	endsequence
	sequence s_irq_off;
		write && !waitrequest && address == fpc_pkg::ADDR_IRQ_EN && writedata[2:0] == 3'h0;
	endsequence
	AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
		else $error("no wait state on new request");
	AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait state longer than one cycle");
	AST_IDLE: assert property (!read && !write |-> !waitrequest)
		else $error("waitrequest with no request");
	AST_UNUSED_ZERO: assert property (s_rd_ctl |-> readdata[31:16] == 16'h0000 && readdata[11:8] == 4'h0)
		else $error("unimplemented control bits not zero");
	AST_MAP: assert property (lower_region_bank2 != upper_region_bank2)
		else $error("bank mapping inconsistent");
	AST_SWAP_CAUSE: assert property ($changed(lower_region_bank2) |-> $past(wr_ctl) || $past(wr_ctl, 2) || !$past(sys_resetn) || !$past(sys_resetn, 2))
		else $error("bank mapping changed without cause");
	AST_SYS_SWAP: assert property (!sys_resetn ##1 !sys_resetn |-> !lower_region_bank2)
		else $error("swap survived other reset");
	AST_IRQ_OFF: assert property (s_irq_off |-> ##2 !irq)
		else $error("irq high with all sources disabled");
endmodule
bind fpc_top fpc_chk chk_i (.*);

// file: tb/fpc_top_tb_top.sv
// Purpose: Directed register-level test of fpc_top
// Assumes: One wait state per access, op 0 or no-op ends in 2 cycles
// Notes: Operations waited out with a fixed margin above 17 cycles
`timescale 1ns/10ps
module flash_program_control_tb_top;
	logic ref_clk = 0, resetn = 0, sys_resetn = 0, read = 0, write = 0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0000_0000, readdata, q;
	logic waitrequest, lower_region_bank2, upper_region_bank2, irq;
	logic [1:0] ecc = 2'h1;
	logic supply_low = 0, cell_fault = 0;
	int num_errors = 0, checks = 0;
	fpc_top uut (.ref_clk(ref_clk), .resetn(resetn), .sys_resetn(sys_resetn),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .dynamic_ecc_config(ecc),
		.supply_low(supply_low), .cell_fault(cell_fault),
		.lower_region_bank2(lower_region_bank2),
		.upper_region_bank2(upper_region_bank2), .irq(irq));
	always #2.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		// Sampled at the rising edge; request held until waitrequest seen low
		do @(posedge ref_clk); while (waitrequest !== 1'b0 && ++n < 50);
		if (n >= 50) chk(32'h0000_0bad, 32'h0000_0000);
		q = readdata;
		write <= 0;
		read <= 0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		bus(0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic unlock();
		bus(1, fpc_pkg::ADDR_KEY, fpc_pkg::KEY1);
		bus(1, fpc_pkg::ADDR_KEY, fpc_pkg::KEY2);
	endtask
	task automatic run_op(input logic [3:0] op, input logic busy, input logic [31:0] exp);
		bus(1, fpc_pkg::ADDR_CTRL, {28'h0000_000, op});
		bus(1, fpc_pkg::ADDR_CTRL, {28'h0000_400, op});
		unlock();
		bus(1, fpc_pkg::ADDR_CTRL, {28'h0000_C00, op});
		if (busy) begin
			rd(fpc_pkg::ADDR_CTRL, {28'h0000_C00, op});
			bus(1, fpc_pkg::ADDR_CTRL, {28'h0000_400, op});
			rd(fpc_pkg::ADDR_CTRL, {28'h0000_C00, op});
		end
		repeat (24) @(posedge ref_clk);
		rd(fpc_pkg::ADDR_CTRL, exp);
	endtask
	task automatic wrap_up();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1;
		sys_resetn <= 1;
		@(posedge ref_clk);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_0000);
		chk({lower_region_bank2, upper_region_bank2}, 32'h0000_0001);
		rd(4'h1, 32'h0000_0000);
		$display("test reset done");
		bus(1, fpc_pkg::ADDR_CTRL, 32'hFFFF_3F03);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_0003);
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_4005);
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_4002);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_4005);
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_C005);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_4005);
		$display("test arm done");
		bus(1, fpc_pkg::ADDR_IRQ_EN, 32'h0000_0007);
		cell_fault <= 1;
		supply_low <= 1;
		run_op(4'h3, 1, 32'h0000_7003);
		chk(irq, 32'h0000_0001);
		rd(fpc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
		bus(1, fpc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
		rd(fpc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
		chk(irq, 32'h0000_0000);
		cell_fault <= 0;
		supply_low <= 0;
		run_op(4'h0, 0, 32'h0000_4000);
		run_op(4'h2, 1, 32'h0000_6002);
		ecc <= 2'h0;
		run_op(4'h0, 0, 32'h0000_4000);
		cell_fault <= 1;
		run_op(4'h3, 0, 32'h0000_4003);
		ecc <= 2'h1;
		cell_fault <= 0;
		bus(1, fpc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
		$display("test operations done");
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_0080);
		// Bank outputs lag the swap bit by one edge
		@(posedge ref_clk);
		chk(lower_region_bank2, 32'h0000_0000);
		unlock();
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_0080);
		@(posedge ref_clk);
		chk({lower_region_bank2, upper_region_bank2}, 32'h0000_0002);
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_4080);
		unlock();
		bus(1, fpc_pkg::ADDR_CTRL, 32'h0000_4000);
		@(posedge ref_clk);
		chk(lower_region_bank2, 32'h0000_0001);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_4080);
		sys_resetn <= 0;
		repeat (3) @(posedge ref_clk);
		sys_resetn <= 1;
		@(posedge ref_clk);
		rd(fpc_pkg::ADDR_CTRL, 32'h0000_4000);
		chk(lower_region_bank2, 32'h0000_0000);
		$display("test swap done");
		wrap_up();
	end
endmodule
